// [flag_ops_defs.svh]
// Constants for the status flag and bit-load instruction block.
`ifndef FLAG_OPS_DEFS_SVH
`define FLAG_OPS_DEFS_SVH
`define FLAG_BIT_CARRY    3'd0
`define FLAG_BIT_ZERO     3'd1
`define FLAG_BIT_NEG      3'd2
`define FLAG_BIT_SIGNED   3'd4
`define FLAG_BIT_TRANSFER 3'd6
`define FLAG_BIT_IRQ      3'd7
`define STATUS_RESET      8'h00
`define GPR_RESET         8'h00
`define GPR_COUNT         32
`endif

// [flag_ops_pkg.sv]
// Types for the status flag and bit-load instruction block.
package flag_ops_pkg;
  typedef enum logic [3:0] {
    op_none,
    op_bit_load_from_transfer,
    op_carry_flag_set,
    op_carry_flag_clear,
    op_negative_flag_set,
    op_negative_flag_clear,
    op_zero_flag_set,
    op_zero_flag_clear,
    op_global_irq_on,
    op_global_irq_off,
    op_signed_flag_set
  } op_type;

  typedef struct packed {
    logic       valid;
    op_type     op;
    logic [4:0] rd;
    logic [2:0] bit_sel;
  } instr_type;
endpackage : flag_ops_pkg

// [status_flag_bit_ops.sv]
// Executes flag set/clear and bit-load-from-transfer instructions in one cycle.
`include "flag_ops_defs.svh"

// Notes on behaviour
// - Bit-load copies transfer flag into Rd bit b, flags unchanged, one cycle.
// - Carry-set forces carry flag to one in one cycle.
// - Carry-clear forces carry flag to zero, touching nothing else.
// - Negative-set writes one to the negative flag only.
// - Negative-clear writes zero to the negative flag only.
// - Zero-set writes one to the zero flag only.
// - Zero-clear writes zero to the zero flag only.
// - Global-irq-on sets the interrupt enable flag, permitting interrupts.
// - Global-irq-off clears the interrupt enable flag, masking interrupts.
// - Signed-set writes one to the signed test flag only.
module status_flag_bit_ops (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire flag_ops_pkg::instr_type instr_i,
  input  wire logic                    transfer_load_i,
  input  wire logic                    transfer_value_i,
  input  wire logic [4:0]              gpr_read_sel_i,
  output logic [7:0]                   status_o,
  output logic [7:0]                   gpr_data_o,
  output logic                         irq_enable_o,
  output logic                         done_o
);
  import flag_ops_pkg::*;

  // Status bit map: carry, zero, negative, signed, transfer and interrupt enable sit at
  // the positions fixed in the constants header. The two remaining bits are spare and
  // no instruction of this group ever writes them, so they keep their reset value.
  // Every output below is a register, so a consumer never sees a combinational glitch.

  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] gpr_reg [`GPR_COUNT];
  logic       done_reg;
  logic [7:0] gpr_data_reg;

  // Next status value: each instruction touches only its own flag.
  // A valid op always wins over a transfer load request in the same cycle.
  always_comb begin
    status_next = status_reg;
    if (instr_i.valid) begin
      unique case (instr_i.op)
        op_carry_flag_set:      status_next[`FLAG_BIT_CARRY]  = 1'b1;
        op_carry_flag_clear:    status_next[`FLAG_BIT_CARRY]  = 1'b0;
        op_negative_flag_set:   status_next[`FLAG_BIT_NEG]    = 1'b1;
        op_negative_flag_clear: status_next[`FLAG_BIT_NEG]    = 1'b0;
        op_zero_flag_set:       status_next[`FLAG_BIT_ZERO]   = 1'b1;
        op_zero_flag_clear:     status_next[`FLAG_BIT_ZERO]   = 1'b0;
        op_global_irq_on:       status_next[`FLAG_BIT_IRQ]    = 1'b1;
        op_global_irq_off:      status_next[`FLAG_BIT_IRQ]    = 1'b0;
        op_signed_flag_set:     status_next[`FLAG_BIT_SIGNED] = 1'b1;
        default:                status_next = status_reg;
      endcase
    end else if (transfer_load_i) begin
      status_next[`FLAG_BIT_TRANSFER] = transfer_value_i;
    end
  end

  // Status register update, one edge per instruction.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_reg <= `STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Register file: only bit-load writes, and only the selected bit.
  // The transfer flag is read as it stood before this edge, before any later load.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < `GPR_COUNT; i++) begin
        gpr_reg[i] <= `GPR_RESET;
      end
    end else if (instr_i.valid && instr_i.op == op_bit_load_from_transfer) begin
      gpr_reg[instr_i.rd][instr_i.bit_sel] <= status_reg[`FLAG_BIT_TRANSFER];
    end
  end

  // Completion pulse and registered read-back port.
  // The read-back lags its select by one edge, so a write shows on the read after it lands.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_reg     <= 1'b0;
      gpr_data_reg <= `GPR_RESET;
    end else begin
      done_reg     <= instr_i.valid && instr_i.op != op_none;
      gpr_data_reg <= gpr_reg[gpr_read_sel_i];
    end
  end

  assign status_o     = status_reg;
  assign irq_enable_o = status_reg[`FLAG_BIT_IRQ];
  assign gpr_data_o   = gpr_data_reg;
  assign done_o       = done_reg;

  // Assertions on flag behaviour.
  // All properties but the reset check sleep while reset is high; an op taken at one edge is judged at
  // the next, since every effect of it is registered; the bit-load register checks wait a second edge for the read-back.
  // The masks below name the single status bit that each op may move.
  a_carry_set_one: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_carry_flag_set |=> status_reg[`FLAG_BIT_CARRY])
    else $error("carry not set");
  a_carry_clear_only: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_carry_flag_clear |=>
    !status_reg[`FLAG_BIT_CARRY] && (status_reg[7:1] == $past(status_reg[7:1])))
    else $error("carry clear wrong");
  a_neg_set_only: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_negative_flag_set |=>
    status_reg == ($past(status_reg) | 8'h04))
    else $error("negative set wrong");
  a_neg_clear_only: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_negative_flag_clear |=>
    status_reg == ($past(status_reg) & 8'hfb))
    else $error("negative clear wrong");
  a_zero_set_only: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_zero_flag_set |=>
    status_reg == ($past(status_reg) | 8'h02))
    else $error("zero set wrong");
  a_zero_clear_only: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_zero_flag_clear |=>
    status_reg == ($past(status_reg) & 8'hfd))
    else $error("zero clear wrong");
  a_irq_on_out: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_global_irq_on |=> irq_enable_o && done_o)
    else $error("irq enable not set");
  a_irq_off_out: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_global_irq_off |=> !irq_enable_o && done_o)
    else $error("irq enable not cleared");
  a_signed_set_only: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_signed_flag_set |=>
    status_reg == ($past(status_reg) | 8'h10))
    else $error("signed set wrong");
  a_bit_load_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_bit_load_from_transfer |=>
    status_reg == $past(status_reg) && done_o)
    else $error("bit load changed flags");

  // Sequences name the steps of the multi-cycle checks; the properties chain them.
  // A bit-load issue; the write lands at the same edge.
  sequence s_bit_load_issue;
    instr_i.valid && instr_i.op == op_bit_load_from_transfer;
  endsequence

  // A bit-load whose target register is also being read back.
  sequence s_bit_load_watched;
    instr_i.valid && instr_i.op == op_bit_load_from_transfer && gpr_read_sel_i == instr_i.rd;
  endsequence

  // The cycle after an issue, the read-back selects the register just written.
  sequence s_same_reg_read;
    gpr_read_sel_i == $past(instr_i.rd);
  endsequence

  // A cycle that cannot write the register file.
  sequence s_no_gpr_write;
    !(instr_i.valid && instr_i.op == op_bit_load_from_transfer);
  endsequence

  // The read-back select did not move since the last edge.
  sequence s_read_held;
    $stable(gpr_read_sel_i);
  endsequence

  // Carry-set and the interrupt ops must leave the other seven flags alone.
  a_carry_set_only: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_carry_flag_set |=>
    status_reg == ($past(status_reg) | (8'h01 << `FLAG_BIT_CARRY)))
    else $error("carry set touched other flags");
  a_irq_on_only: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_global_irq_on |=>
    status_reg == ($past(status_reg) | (8'h01 << `FLAG_BIT_IRQ)))
    else $error("irq on touched other flags");
  a_irq_off_only: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_global_irq_off |=>
    status_reg == ($past(status_reg) & ~(8'h01 << `FLAG_BIT_IRQ)))
    else $error("irq off touched other flags");

  // A valid no-op and an idle cycle without a load leave the status as it was.
  a_op_none_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op == op_none |=> $stable(status_reg))
    else $error("no-op changed status");
  a_idle_status_held: assert property (@(posedge clk_i) disable iff (rst_i)
    !instr_i.valid && !transfer_load_i |=> $stable(status_reg))
    else $error("idle cycle changed status");

  // The transfer flag holds while any instruction of the group runs.
  a_transfer_held: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid |=> status_reg[`FLAG_BIT_TRANSFER] == $past(status_reg[`FLAG_BIT_TRANSFER]))
    else $error("transfer flag moved under an instruction");
  // On an idle cycle the load request copies its value into the transfer flag.
  a_transfer_load: assert property (@(posedge clk_i) disable iff (rst_i)
    !instr_i.valid && transfer_load_i |=>
    status_reg[`FLAG_BIT_TRANSFER] == $past(transfer_value_i))
    else $error("transfer flag not loaded");

  // The completion pulse follows every executed op and nothing else.
  a_done_after_op: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_i.valid && instr_i.op != op_none |=> done_o)
    else $error("done missing after op");
  a_done_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !instr_i.valid || instr_i.op == op_none |=> !done_o)
    else $error("done raised without op");

  // Bit-load writes the chosen bit and spares the other seven.
  a_bit_load_value: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bit_load_issue ##1 s_same_reg_read |=>
    gpr_data_o[$past(instr_i.bit_sel, 2)] == $past(status_reg[`FLAG_BIT_TRANSFER], 2))
    else $error("bit load wrote wrong value");
  a_bit_load_others: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bit_load_watched ##1 s_same_reg_read |=>
    (gpr_data_o & ~(8'h01 << $past(instr_i.bit_sel, 2))) ==
    ($past(gpr_data_o) & ~(8'h01 << $past(instr_i.bit_sel, 2))))
    else $error("bit load touched other bits");

  // A cycle with no bit-load leaves the register under read-back unchanged.
  a_gpr_untouched: assert property (@(posedge clk_i) disable iff (rst_i)
    s_no_gpr_write ##1 s_read_held |=> $stable(gpr_data_o))
    else $error("register changed without bit load");

  // While reset is seen at an edge, the outputs show their reset values at the next one.
  a_reset_clears: assert property (@(posedge clk_i)
    rst_i |=> status_o == `STATUS_RESET && gpr_data_o == `GPR_RESET && !done_o)
    else $error("outputs not at reset values");
endmodule : status_flag_bit_ops

// [status_flag_bit_ops_bench.sv]
// Random self-checking bench for the status flag and bit-load block.
`include "flag_ops_defs.svh"
module status_flag_bit_ops_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import flag_ops_pkg::*;
  logic       clk_i, rst_i, transfer_load_i, transfer_value_i, irq_enable_o, done_o, done_model;
  instr_type  instr_i;
  logic [4:0] gpr_read_sel_i, last_rd;
  logic [7:0] status_o, gpr_data_o, st_model, rd_model;
  logic [7:0] gpr_model [32];
  int         errors, total_checks, seed, cycles;
  status_flag_bit_ops uut (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .transfer_load_i(transfer_load_i),
    .transfer_value_i(transfer_value_i), .gpr_read_sel_i(gpr_read_sel_i), .status_o(status_o),
    .gpr_data_o(gpr_data_o), .irq_enable_o(irq_enable_o), .done_o(done_o));
  // Free-running clock at 250 MHz.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Counts mismatches, each with a one-line report.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // Status after one flag instruction; only the target bit moves.
  function automatic logic [7:0] next_status(input logic [7:0] s, input op_type op);
    case (op)
      op_carry_flag_set:      s[`FLAG_BIT_CARRY] = 1'b1;
      op_carry_flag_clear:    s[`FLAG_BIT_CARRY] = 1'b0;
      op_negative_flag_set:   s[`FLAG_BIT_NEG] = 1'b1;
      op_negative_flag_clear: s[`FLAG_BIT_NEG] = 1'b0;
      op_zero_flag_set:       s[`FLAG_BIT_ZERO] = 1'b1;
      op_zero_flag_clear:     s[`FLAG_BIT_ZERO] = 1'b0;
      op_global_irq_on:       s[`FLAG_BIT_IRQ] = 1'b1;
      op_global_irq_off:      s[`FLAG_BIT_IRQ] = 1'b0;
      op_signed_flag_set:     s[`FLAG_BIT_SIGNED] = 1'b1;
      default:                s = s;
    endcase
    return s;
  endfunction : next_status
  // Cuts a hang short.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 3000) begin
      errors++;
      summarize();
    end
  end
  // Checks what the last edge produced, then drives the next instruction and models it.
  task automatic step(input instr_type ins, input logic tl, input logic tv, input logic [4:0] sel);
    @(negedge clk_i);
    chk("status", st_model, status_o);
    chk("irq_enable", {7'h00, st_model[`FLAG_BIT_IRQ]}, {7'h00, irq_enable_o});
    chk("done", {7'h00, done_model}, {7'h00, done_o});
    chk("gpr_data", rd_model, gpr_data_o);
    instr_i = ins;
    transfer_load_i = tl;
    transfer_value_i = tv;
    gpr_read_sel_i = sel;
    rd_model = gpr_model[sel];
    done_model = ins.valid && ins.op != op_none;
    if (ins.valid && ins.op == op_bit_load_from_transfer) begin
      gpr_model[ins.rd][ins.bit_sel] = st_model[`FLAG_BIT_TRANSFER];
      last_rd = ins.rd;
    end else if (ins.valid) begin
      st_model = next_status(st_model, ins.op);
    end else if (tl) begin
      st_model[`FLAG_BIT_TRANSFER] = tv;
    end
  endtask : step
  // Reset, hand-written corners, then random back-to-back instructions with a reset in mid-run.
  initial begin
    seed = 19820;
    rst_i = 1'b1;
    instr_i = '0;
    {transfer_load_i, transfer_value_i, gpr_read_sel_i, last_rd, st_model, rd_model, done_model} = '0;
    foreach (gpr_model[i]) gpr_model[i] = 8'h00;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i) rst_i = 1'b0;
    step('{1'b0, op_none, 5'd0, 3'd0}, 1'b1, 1'b1, 5'd31);
    for (int b = 0; b < 8; b++) begin
      step('{1'b1, op_bit_load_from_transfer, 5'd31, 3'(b)}, 1'b0, 1'b0, 5'd31);
    end
    for (int k = 2; k < 11; k += 2) begin
      step('{1'b1, op_type'(4'(k)), 5'd0, 3'd0}, 1'b1, 1'b0, 5'd31);
    end
    for (int k = 3; k < 11; k += 2) begin
      step('{1'b1, op_type'(4'(k)), 5'd0, 3'd0}, 1'b1, 1'b0, 5'd31);
    end
    step('{1'b1, op_none, 5'd0, 3'd0}, 1'b1, 1'b0, 5'd31);
    step('{1'b0, op_none, 5'd0, 3'd0}, 1'b1, 1'b0, 5'd31);
    step('{1'b1, op_bit_load_from_transfer, 5'd31, 3'd0}, 1'b0, 1'b0, 5'd31);
    for (int n = 0; n < 1500; n++) begin
      instr_type rand_ins;
      if (n == 750) begin
        @(negedge clk_i);
        rst_i = 1'b1;
        instr_i = '0;
        transfer_load_i = 1'b0;
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        {st_model, rd_model, done_model, last_rd} = '0;
        foreach (gpr_model[i]) gpr_model[i] = 8'h00;
      end
      rand_ins.valid = ($random(seed) & 3) != 0;
      rand_ins.op = op_type'(4'(($random(seed) & 32'h7fffffff) % 11));
      rand_ins.rd = 5'($random(seed));
      rand_ins.bit_sel = 3'($random(seed));
      step(rand_ins, 1'($random(seed)), 1'($random(seed)), ($random(seed) & 1) ? last_rd : 5'($random(seed)));
    end
    summarize();
  end
endmodule : status_flag_bit_ops_bench
